// >>> uvr_regs.vh
// constants for the undervoltage and runaway supervisory reset block
`ifndef UVR_REGS_VH
`define UVR_REGS_VH

// runaway counter width and interval, 2^20 oscillation periods
`define UVR_CNT_W        20
`define UVR_CNT_MAX      20'hfffff
// standby recovery extension in microseconds, oscillation rate in MHz
`define UVR_EXT_US       20
`define UVR_OSC_MHZ      4
// machine clock rate in MHz
`define UVR_SYS_MHZ      25
// runaway reset width in machine cycles
`define UVR_RST_CYC      3'h5
`define UVR_RST_W        3
// extension counter width
`define UVR_EXT_W        10
// extension length in oscillation ticks, 20 us at 4 MHz
`define UVR_EXT_CNT      10'h050

`endif

// >>> uvr_sync.v
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none

module uvr_sync
(
  // clock and reset
  input  wire clk_sys,
  input  wire rst,
  // level
  input  wire d_in,
  output wire q_out
);

  reg meta_r;
  reg sync_r;

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;

endmodule

`default_nettype wire

// >>> uvr_supervisor.v
// undervoltage and cpu runaway supervisory reset block
`timescale 1ns/1ps
`default_nettype none
`include "uvr_regs.vh"

module uvr_supervisor
(
  // clock and reset
  input  wire                  clk_sys,
  input  wire                  rst,
  // oscillation clock tick, one machine cycle wide
  input  wire                  osc_tick,
  // analog comparator level, asynchronous
  input  wire                  low_volt_async,
  // cpu mode status
  input  wire                  cpu_halted,
  input  wire                  osc_stopped,
  input  wire                  enter_sleep,
  input  wire                  enter_tbt_watch,
  input  wire                  standby_recover,
  input  wire                  ram_write_busy,
  // software access to the reset control register
  input  wire                  ctrl_wr,
  input  wire                  counter_clear_bit,
  input  wire                  flag_clear,
  // outputs
  output reg                   undervoltage_flag,
  output reg                   stop_release,
  output reg                   lv_reset_out,
  output reg                   internal_reset
);

  // -----------------------------------------------------------------
  // timing constants
  // -----------------------------------------------------------------
  localparam [`UVR_EXT_W-1:0] EXT_OSC = `UVR_EXT_CNT;

  // -----------------------------------------------------------------
  // input synchronisation
  // -----------------------------------------------------------------
  wire low_volt;

  uvr_sync u_lv_sync
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d_in    (low_volt_async),
    .q_out   (low_volt)
  );

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  reg  [`UVR_CNT_W-1:0] cnt_r;
  reg  [`UVR_CNT_W-1:0] cnt_nxt;
  reg  [`UVR_EXT_W-1:0] ext_r;
  reg  [`UVR_EXT_W-1:0] ext_nxt;
  reg                   ext_act_r;
  reg                   ext_act_nxt;
  reg  [`UVR_RST_W-1:0] pulse_r;
  reg  [`UVR_RST_W-1:0] pulse_nxt;
  reg                   lv_pend_r;
  reg                   lv_pend_nxt;
  reg                   flag_nxt;
  reg                   ireset_nxt;
  reg                   lvout_nxt;
  reg                   release_nxt;
  wire                  cnt_clr;
  wire                  expire;
  wire                  lv_fire;

  // -----------------------------------------------------------------
  // runaway counter
  // -----------------------------------------------------------------
  // zero clears
  assign cnt_clr = (ctrl_wr && !counter_clear_bit) || internal_reset ||
                   osc_stopped || enter_sleep || enter_tbt_watch;

  assign expire = osc_tick && !cpu_halted && (cnt_r == `UVR_CNT_MAX) &&
                  (!ext_act_r || (ext_r == EXT_OSC));

  always @*
  begin
    cnt_nxt     = cnt_r;
    ext_nxt     = ext_r;
    ext_act_nxt = ext_act_r;
    if (standby_recover)
      ext_act_nxt = 1'b1;
    if (cnt_clr)
    begin
      cnt_nxt     = {`UVR_CNT_W{1'b0}};
      ext_nxt     = {`UVR_EXT_W{1'b0}};
      ext_act_nxt = standby_recover;
    end
    else if (osc_tick && !cpu_halted)
    begin
      if (cnt_r != `UVR_CNT_MAX)
        cnt_nxt = cnt_r + 1'b1;
      else if (ext_act_r && (ext_r != EXT_OSC))
        ext_nxt = ext_r + 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // low voltage path
  // -----------------------------------------------------------------
  // wait for write
  assign lv_fire = (low_volt || lv_pend_r) && !ram_write_busy;

  always @*
  begin
    lv_pend_nxt = lv_pend_r;
    flag_nxt    = undervoltage_flag;
    if (flag_clear)
      flag_nxt = 1'b0;
    // set flag, set wins over clear
    if (low_volt)
      flag_nxt = 1'b1;
    if (low_volt && ram_write_busy)
      lv_pend_nxt = 1'b1;
    else if (lv_fire)
      lv_pend_nxt = 1'b0;
    lvout_nxt   = lv_fire && !internal_reset;
    release_nxt = lv_fire && !internal_reset;
  end

  // -----------------------------------------------------------------
  // merged internal reset
  // -----------------------------------------------------------------
  always @*
  begin
    pulse_nxt = pulse_r;
    if (expire && (pulse_r == {`UVR_RST_W{1'b0}}))
      pulse_nxt = `UVR_RST_CYC;
    else if (pulse_r != {`UVR_RST_W{1'b0}})
      pulse_nxt = pulse_r - 1'b1;
    // merge requests
    // raw request, not the suppressed output, so reset holds steady under low supply
    ireset_nxt = (pulse_nxt != {`UVR_RST_W{1'b0}}) || lv_fire;
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  // counts from reset release
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt_r             <= {`UVR_CNT_W{1'b0}};
      ext_r             <= {`UVR_EXT_W{1'b0}};
      ext_act_r         <= 1'b0;
      pulse_r           <= {`UVR_RST_W{1'b0}};
      lv_pend_r         <= 1'b0;
      undervoltage_flag <= 1'b0;
      stop_release      <= 1'b0;
      lv_reset_out      <= 1'b0;
      internal_reset    <= 1'b0;
    end
    else
    begin
      cnt_r             <= cnt_nxt;
      ext_r             <= ext_nxt;
      ext_act_r         <= ext_act_nxt;
      pulse_r           <= pulse_nxt;
      lv_pend_r         <= lv_pend_nxt;
      undervoltage_flag <= flag_nxt;
      stop_release      <= release_nxt;
      lv_reset_out      <= lvout_nxt;
      internal_reset    <= ireset_nxt;
    end
  end

endmodule

`default_nettype wire

// >>> uvr_monitor.sv
// checker for the supervisory reset block
`timescale 1ns/1ps
`default_nettype none
module uvr_monitor
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // watched inputs
  input wire logic low_volt_async,
  input wire logic ram_write_busy,
  // outputs
  input wire logic undervoltage_flag,
  input wire logic stop_release,
  input wire logic lv_reset_out,
  input wire logic internal_reset
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_lv_sets_flag:
    assert property (lv_reset_out |-> ##[0:1] undervoltage_flag) else $error("flag missing");
  chk_lv_fires:
    assert property ((low_volt_async && !ram_write_busy)[*5] |-> internal_reset) else $error("no reset");
  chk_lv_quiet:
    assert property ((!low_volt_async && !ram_write_busy)[*4] |-> !lv_reset_out) else $error("spurious lv reset");
  chk_ram_wait:
    assert property (ram_write_busy[*2] |-> !lv_reset_out) else $error("lv reset in write");
  chk_lv_suppress:
    assert property (lv_reset_out |=> !lv_reset_out) else $error("lv not suppressed");
  chk_merge_out:
    assert property (lv_reset_out |-> internal_reset) else $error("lv not merged");
  chk_stop_exit:
    assert property (stop_release |-> ##[0:1] undervoltage_flag) else $error("bad stop release");
  chk_run_width:
    assert property ($rose(internal_reset) && !low_volt_async && !lv_reset_out |-> internal_reset[*5] ##1
      !internal_reset) else $error("runaway width");
  chk_rst_quiet:
    assert property (disable iff (1'b0) rst |=> !internal_reset && !undervoltage_flag) else $error("reset");
  cover property (lv_reset_out);
  cover property (stop_release);
  cover property (undervoltage_flag && !low_volt_async);
endmodule
bind uvr_supervisor uvr_monitor i_uvr_monitor (.clk_sys(clk_sys), .rst(rst), .low_volt_async(low_volt_async),
  .ram_write_busy(ram_write_busy), .undervoltage_flag(undervoltage_flag), .stop_release(stop_release),
  .lv_reset_out(lv_reset_out), .internal_reset(internal_reset));
`default_nettype wire

// >>> uvr_sw_model.sv
// software model that services the runaway counter
`timescale 1ns/1ps
`default_nettype none
module uvr_sw_model
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // reset control register write
  output var  logic ctrl_wr = 1'b0,
  output var  logic counter_clear_bit = 1'b1
);
  logic [5:0] gap_r = 6'h00;
  always @(negedge clk_sys)
  begin
    gap_r <= rst ? 6'h00 : gap_r + 6'h01;
    ctrl_wr <= !rst && (gap_r == 6'h3f);
    counter_clear_bit <= !(gap_r == 6'h3f);
  end
endmodule
`default_nettype wire

// >>> test_undervoltage_runaway_reset.sv
// self-checking bench for the supervisory reset block
`timescale 1ns/1ps
`default_nettype none
module test_undervoltage_runaway_reset;
  logic       clk_sys  = 1'b0;
  logic       rst      = 1'b1;
  logic       osc_tick = 1'b0;
  logic       lv       = 1'b0;
  logic       busy     = 1'b0;
  logic       fclr     = 1'b0;
  logic [4:0] mode     = 5'h00;
  wire        ctrl_wr;
  wire        clr_bit;
  wire        flag;
  wire        ir;
  wire        lvo;
  wire        srel;
  int         n_mismatch = 0;
  int         n_checks   = 0;
  // rows: low voltage, write busy, flag clear, expected reset, expected flag
  logic [4:0] rows [0:5] = '{5'h00, 5'h13, 5'h01, 5'h04, 5'h19, 5'h13};
  always #20 clk_sys = ~clk_sys;
  always @(negedge clk_sys) osc_tick <= ~osc_tick;
  uvr_sw_model i_uvr_sw_model (.clk_sys(clk_sys), .rst(rst), .ctrl_wr(ctrl_wr), .counter_clear_bit(clr_bit));
  uvr_supervisor i_uvr_supervisor (.clk_sys(clk_sys), .rst(rst), .osc_tick(osc_tick), .low_volt_async(lv),
    .cpu_halted(mode[0]), .osc_stopped(mode[1]), .enter_sleep(mode[2]), .enter_tbt_watch(mode[3]),
    .standby_recover(mode[4]), .ram_write_busy(busy), .ctrl_wr(ctrl_wr), .counter_clear_bit(clr_bit),
    .flag_clear(fclr), .undervoltage_flag(flag), .stop_release(srel), .lv_reset_out(lvo), .internal_reset(ir));
  task automatic check(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      {lv, busy, fclr} = rows[i][4:2];
      repeat (8) @(negedge clk_sys);
      check(ir, rows[i][1], "merged reset");
      check(flag, rows[i][0], "undervoltage flag");
      $display("row %0d done", i);
    end
    // low voltage caught in a write fires once the write ends
    check(lvo, 1'b0, "lv output not suppressed");
    busy = 1'b1;
    repeat (8) @(negedge clk_sys);
    lv = 1'b0;
    repeat (8) @(negedge clk_sys);
    check(ir, 1'b0, "reset during write");
    busy = 1'b0;
    @(negedge clk_sys);
    check(ir, 1'b1, "delayed reset missing");
    check(lvo, 1'b1, "lv path reset missing");
    check(srel, 1'b1, "stop release missing");
    @(negedge clk_sys);
    check(ir, 1'b0, "delayed reset repeated");
    check(lvo, 1'b0, "lv path reset too long");
    $display("write delay test done");
    // quiet in every halt, stop and entry mode
    lv = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      mode = 5'h01 << i;
      repeat (8) @(negedge clk_sys);
      check(ir, 1'b0, "reset in mode");
    end
    mode = 5'h00;
    lv = 1'b1;
    repeat (8) @(negedge clk_sys);
    rst = 1'b1;
    @(negedge clk_sys);
    check(ir, 1'b0, "reset not cleared");
    check(flag, 1'b0, "flag not cleared");
    $display("mode and reset tests done");
    print_verdict();
  end
  initial
  begin
    #(40 * 2000);
    n_mismatch++;
    print_verdict();
  end
endmodule
`default_nettype wire
